// ===== verilog/bpd_pkg.sv
// Purpose: Shared constants for the baseband phase detector.
// Assumes: Symbol-rate clock; 8-bit two's complement samples.
// Notes: Gain words are Q2.14, so unity is 16'h4000.
`default_nettype none
package bpd_pkg;
    // ==========================================================
    // Widths
    localparam int SAMPLE_W = 8;      // Discriminator sample
    localparam int CHAIN_LEN = 4;     // Holding registers in the screen chain
    localparam int WORD_W = 12;       // Phase word, one turn full scale
    localparam int ERR_W = 10;        // Error-to-node, a quarter turn
    localparam int GAIN_W = 16;       // Gain correction factor
    localparam int PROD_W = 32;       // Multiplier product
    localparam int OUT_W = WORD_W + ERR_W + GAIN_W;  // Buffered result word

    // ==========================================================
    // Field positions and scaling
    localparam int FIELD_LSB = 10;    // Product bits [21:10] carry the word
    localparam int LEAD_SHIFT = 2;    // Lead term gain of one quarter
    localparam int AGC_SHIFT = 2;     // Extra AGC loop gain of one quarter

    // ==========================================================
    // Gain values
    localparam logic [GAIN_W-1:0] GAIN_ONE = 16'h4000;   // Unity gain
    localparam logic [GAIN_W-1:0] GAIN_SPAN = 16'h0400;  // 0.0625 of unity
    // Accumulator limit, before the quarter-gain wiring
    localparam logic signed [GAIN_W-1:0] AGC_LIMIT = 16'sh1000;

    // ==========================================================
    // Update cadence
    localparam logic [1:0] SLOW_LAST = 2'h3;  // Fourth symbol in tracking

    // Quarter-scaled error, sign-extended to the word width
    function automatic logic [WORD_W-1:0] lead_of(input logic [ERR_W-1:0] err);
        lead_of = {{(WORD_W-ERR_W+LEAD_SHIFT){err[ERR_W-1]}}, err[ERR_W-1:LEAD_SHIFT]};
    endfunction

    // Error sign-extended to the word width
    function automatic logic [WORD_W-1:0] ext_of(input logic [ERR_W-1:0] err);
        ext_of = {{(WORD_W-ERR_W){err[ERR_W-1]}}, err};
    endfunction
endpackage
`default_nettype wire

// ===== verilog/bpd_fifo.sv
// Purpose: Small register FIFO between the detector and its receiver.
// Assumes: Single clock; head entry is always at index zero.
// Notes: Ready and valid are flops so the top drives them directly.
`timescale 1ns/1ns
`default_nettype none
module bpd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int CNT_W = $clog2(DEPTH + 1);

    // ==========================================================
    // Parameter screen
    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("bpd_fifo: DEPTH must be at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];  // Entry zero is the head
    logic [CNT_W-1:0] count;        // Words held
    logic push;
    logic pop;
    logic [CNT_W-1:0] next_count;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign next_count = count + CNT_W'(push) - CNT_W'(pop);
    assign out_data_o = mem[0];

    // ==========================================================
    // Occupancy and flags; ready only drops when truly full
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            count <= next_count;
            in_ready_o <= (next_count != CNT_W'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end

    // ==========================================================
    // Storage: shift towards the head on pop, write behind the tail
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && (CNT_W'(i) == count - CNT_W'(pop))) begin
                    mem[i] <= in_data_i;
                end else if (pop && i < DEPTH - 1) begin
                    mem[i] <= mem[i+1];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/bpd_detector.sv
// Purpose: Baseband phase detector with DC restore and AGC loops.
// Assumes: One sample per symbol clock; burst markers from the sequencer.
// Notes: Loop registers sit under a clear that follows the tone lock.
`timescale 1ns/1ns
`default_nettype none
module bpd_detector #(
    parameter logic signed [7:0] TONE_LEVEL = 8'sh60,  // Ideal tone sample
    parameter logic [7:0] TONE_TOL = 8'h10,            // Screen tolerance
    parameter int BUF_DEPTH = 2                        // Result buffer depth
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sample stream
    input wire logic [7:0] sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    // Burst control
    input wire logic burst_start_i,
    input wire logic burst_end_i,
    input wire logic data_mode_i,
    // Results
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [11:0] phase_o,
    output logic [9:0] err_node_o,
    output logic [15:0] gain_o,
    output logic tone_lock_o
);
    localparam int W = bpd_pkg::WORD_W;
    localparam int EW = bpd_pkg::ERR_W;
    localparam int GW = bpd_pkg::GAIN_W;
    localparam int PW = bpd_pkg::PROD_W;
    // Offset that maps an ideal tone at unity gain onto zero
    localparam logic signed [PW-1:0] REF_SUM =
        -(PW'(TONE_LEVEL) * $signed({16'h0000, bpd_pkg::GAIN_ONE}));

    // ==========================================================
    // Parameter screen
    initial begin
        if (BUF_DEPTH < 2 || TONE_TOL > 8'h7f) begin
            $error("bpd_detector: unsupported buffer depth or tolerance");
        end
    end

    // Sample within tolerance of the tone level
    function automatic logic is_tone(input logic [7:0] s);
        logic signed [8:0] d;
        d = $signed({s[7], s}) - $signed({TONE_LEVEL[7], TONE_LEVEL});
        is_tone = (d <= $signed({1'b0, TONE_TOL})) && (d >= -$signed({1'b0, TONE_TOL}));
    endfunction

    // ==========================================================
    // Declarations
    logic [7:0] chain [bpd_pkg::CHAIN_LEN];  // Screen chain, [3] feeds the multiplier
    logic track_en;         // Tone lock, releases the loop registers
    logic clr_n;            // Loop clear, low while unlocked
    logic buf_ready;        // Buffer has room
    logic step;             // A sample is taken this edge
    logic all_tone;         // Whole chain shows the tone
    logic [W-1:0] pre;      // Preprocessed word
    logic [W-1:0] acc;      // Phase accumulator
    logic [W-1:0] dc_corr;  // DC restore correction
    logic [GW-1:0] agc_acc; // AGC accumulator
    logic [1:0] slow_cnt;   // Symbol phase for the slow cadence
    logic sign_d1;          // Sample sign, one stage late
    logic sign_d2;          // Sample sign, aligned with the error
    logic loop_upd;         // Loops take an update
    logic [EW-1:0] err;     // Error-to-node
    logic [W-1:0] sum;      // DC-restored word
    logic [W-1:0] acc_next; // Accumulator after this symbol, wraps freely
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] prod_sum;
    logic [GW-1:0] gain;    // Gain correction factor
    logic [GW-1:0] gerr;    // Gain error term
    logic signed [GW-1:0] agc_next;

    assign step = sample_valid_i && buf_ready;
    assign clr_n = rst_n_i && track_en;
    assign all_tone = is_tone(chain[0]) && is_tone(chain[1])
                   && is_tone(chain[2]) && is_tone(chain[3]);
    assign sample_ready_o = buf_ready;
    assign tone_lock_o = track_en;

    // ==========================================================
    // Screen chain; runs under the plain reset only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < bpd_pkg::CHAIN_LEN; i++) begin
                chain[i] <= '0;
            end
        end else if (step) begin
            chain[0] <= sample_i;
            for (int i = 1; i < bpd_pkg::CHAIN_LEN; i++) begin
                chain[i] <= chain[i-1];
            end
        end
    end

    // ==========================================================
    // Tone lock; held through the data part, dropped at burst end.
    // A flop drives the clear, so it cannot glitch.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            track_en <= 1'b0;
        end else if (burst_end_i) begin
            track_en <= 1'b0;
        end else if (step && all_tone) begin
            track_en <= 1'b1;
        end
    end

    // ==========================================================
    // Preprocessor: gain multiply, reference add, field select
    assign prod = $signed({{8{chain[3][7]}}, chain[3]}) * $signed(gain);
    assign prod_sum = prod + REF_SUM;

    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            pre <= '0;
        end else if (step) begin
            pre <= prod_sum[bpd_pkg::FIELD_LSB +: W];
        end
    end

    // ==========================================================
    // Update cadence: every symbol in the preamble, every fourth after
    assign loop_upd = !data_mode_i || (slow_cnt == bpd_pkg::SLOW_LAST);

    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            slow_cnt <= '0;
        end else if (step) begin
            slow_cnt <= slow_cnt + 2'h1;
        end
    end

    // ==========================================================
    // Phase accumulator with DC restore
    assign sum = pre + dc_corr;
    assign acc_next = acc + sum;
    assign err = acc[EW-1:0];

    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            acc <= '0;
        end else if (burst_start_i) begin
            acc <= '0;
        end else if (step) begin
            acc <= acc_next;
        end
    end

    // Lead term; the fast rate widens the loop for acquisition
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            dc_corr <= '0;
        end else if (step && loop_upd) begin
            dc_corr <= bpd_pkg::lead_of(err);
        end
    end

    // ==========================================================
    // AGC loop; sign delayed to line up with the error it explains
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            sign_d1 <= 1'b0;
            sign_d2 <= 1'b0;
        end else if (step) begin
            sign_d1 <= chain[3][7];
            sign_d2 <= sign_d1;
        end
    end

    // Sign-extend before negating; a zero-filled widening would turn
    // small negative errors into large positive ones
    assign gerr = sign_d2 ? GW'(-$signed(bpd_pkg::ext_of(err)))
                          : GW'($signed(bpd_pkg::ext_of(err)));
    assign agc_next = $signed(agc_acc) + $signed(gerr);

    // Saturating accumulator keeps the factor inside its span
    always_ff @(posedge clk_i or negedge clr_n) begin
        if (!clr_n) begin
            agc_acc <= '0;
        end else if (step && loop_upd) begin
            if (agc_next > bpd_pkg::AGC_LIMIT) begin
                agc_acc <= bpd_pkg::AGC_LIMIT;
            end else if (agc_next < -bpd_pkg::AGC_LIMIT) begin
                agc_acc <= GW'(-bpd_pkg::AGC_LIMIT);
            end else begin
                agc_acc <= agc_next;
            end
        end
    end

    // Quarter gain is pure wiring: the accumulator enters two bits down
    assign gain = bpd_pkg::GAIN_ONE
                + {{bpd_pkg::AGC_SHIFT{agc_acc[GW-1]}}, agc_acc[GW-1:bpd_pkg::AGC_SHIFT]};

    // ==========================================================
    // Result buffer; a full buffer stalls the whole pipeline
    bpd_fifo #(
        .WIDTH(bpd_pkg::OUT_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(step && track_en),
        .in_ready_o(buf_ready),
        .in_data_i({acc, err, gain}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({phase_o, err_node_o, gain_o})
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_chain;
        step |=> (chain[0] == $past(sample_i)) && (chain[1] == $past(chain[0]))
            && (chain[3] == $past(chain[2]));
    endproperty
    a_chain: assert property (p_chain) else $error("sample chain did not shift");

    property p_lock;
        (step && all_tone && !burst_end_i) |=> track_en;
    endproperty
    a_lock: assert property (p_lock) else $error("tone seen but loops held");

    property p_hold;
        !track_en |-> (acc == '0) && (pre == '0) && (agc_acc == '0) && (dc_corr == '0);
    endproperty
    a_hold: assert property (p_hold) else $error("loop register not cleared");

    property p_zero_ref;
        (step && track_en && !burst_end_i && chain[3] == TONE_LEVEL && agc_acc == '0)
            |=> (pre == '0);
    endproperty
    a_zero_ref: assert property (p_zero_ref) else $error("ideal tone not zero");

    property p_acc;
        (step && track_en && !burst_end_i && !burst_start_i)
            |=> (acc == W'($past(acc) + $past(pre) + $past(dc_corr)));
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator sum wrong");

    property p_clear;
        (burst_start_i && !burst_end_i) |=> (acc == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("burst start left phase");

    property p_dc_slow;
        (data_mode_i && step && track_en && !burst_end_i && slow_cnt != 2'h3)
            |=> $stable(dc_corr) && $stable(agc_acc);
    endproperty
    a_dc_slow: assert property (p_dc_slow) else $error("loop updated off cadence");

    property p_dc_fast;
        (!data_mode_i && step && track_en && !burst_end_i)
            |=> ($signed(dc_corr) == ($signed($past(err)) >>> 2));
    endproperty
    a_dc_fast: assert property (p_dc_fast) else $error("lead term not refreshed");

    property p_gain_span;
        (gain <= bpd_pkg::GAIN_ONE + bpd_pkg::GAIN_SPAN)
            && (gain >= bpd_pkg::GAIN_ONE - bpd_pkg::GAIN_SPAN);
    endproperty
    a_gain_span: assert property (p_gain_span) else $error("gain outside span");

    property p_agc_fast;
        (!data_mode_i && step && track_en && !burst_end_i && gerr != '0
            && agc_acc != bpd_pkg::AGC_LIMIT && agc_acc != GW'(-bpd_pkg::AGC_LIMIT))
            |=> !$stable(agc_acc);
    endproperty
    a_agc_fast: assert property (p_agc_fast) else $error("AGC missed a symbol");

    c_lock: cover property ($rose(track_en));
    c_wrap: cover property (step && track_en && (acc_next < acc));
    c_slow: cover property (data_mode_i && step && track_en && loop_upd);
    c_stall: cover property (sample_valid_i && !buf_ready);
    c_gain_top: cover property (agc_acc == bpd_pkg::AGC_LIMIT);
endmodule
`default_nettype wire

// ===== tb/bpd_sampler_model.sv
// Purpose: Behavioural sample source standing in for the sampler cards.
// Assumes: Requests change just after a rising edge and hold until taken.
// Notes: Between offers the data lines show the inverse of the last word, or the word itself in the gap of a send after stop.
`timescale 1ns/1ns
`default_nettype none
module bpd_sampler_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sample offer
    output logic [7:0] sample_o,
    output logic valid_o,
    input wire logic ready_i
);
    // ==========================================================
    // Idle state at time zero
    initial begin
        sample_o = 8'h00;
        valid_o = 1'b0;
    end

    // ==========================================================
    // Offer one word after gap idle cycles; valid stays up on return
    // so back-to-back offers never assign the strobe twice in a step
    task automatic send(input logic [7:0] s, input int gap);
        int n;
        n = 0;
        if (gap > 0) begin
            // Slow source: released lines must not keep the last word
            valid_o <= 1'b0;
            sample_o <= ~sample_o;
            repeat (gap) @(posedge clk_i);
        end
        sample_o <= s;
        valid_o <= 1'b1;
        @(posedge clk_i);
        // Hold until the block shows room; bounded so a hang stays visible
        while ((ready_i !== 1'b1 || rst_n_i !== 1'b1) && n < 200) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // Release the offer at the edge where the last word was taken
    task automatic stop();
        valid_o <= 1'b0;
        sample_o <= ~sample_o;
    endtask
endmodule
`default_nettype wire

// ===== tb/baseband_phase_detector_bench.sv
// Purpose: Self-checking bench for the baseband phase detector.
// Assumes: Default tone level 60h, unity gain 4000h, product field [21:10].
// Notes: Words are collected at each pop and judged by the scenarios.
`timescale 1ns/1ns
`default_nettype none
module baseband_phase_detector_bench;
    // ==========================================================
    // Stimulus and observation
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] sample_i;
    logic sample_valid_i;
    logic sample_ready_o;
    logic burst_start_i = 1'b0;
    logic burst_end_i = 1'b0;
    logic data_mode_i = 1'b0;
    logic out_valid_o;
    logic out_ready_i = 1'b1;
    logic [11:0] phase_o;
    logic [9:0] err_node_o;
    logic [15:0] gain_o;
    logic tone_lock_o;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [11:0] phases[$]; // Phase of every popped word
    logic [11:0] first_nz;

    // 125 MHz symbol clock
    always #4 clk_i = ~clk_i;

    bpd_detector i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_i(sample_i),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .burst_start_i(burst_start_i), .burst_end_i(burst_end_i),
        .data_mode_i(data_mode_i), .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i), .phase_o(phase_o), .err_node_o(err_node_o),
        .gain_o(gain_o), .tone_lock_o(tone_lock_o));

    bpd_sampler_model i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_o(sample_i),
        .valid_o(sample_valid_i), .ready_i(sample_ready_o));

    // ==========================================================
    // Comparison and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Collect popped words; field and range checks hold for every word
    always @(posedge clk_i) begin
        cycles++;
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            phases.push_back(phase_o);
            check({22'h0, err_node_o}, {22'h0, phase_o[9:0]}, "error field");
            check({31'h0, (gain_o >= 16'h3c00 && gain_o <= 16'h4400)}, 32'h1, "gain span");
        end
        // Whole run needs about 110 cycles; a hang ends it here
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    // ==========================================================
    // Helpers
    task automatic feed(input logic [7:0] v, input int n, input int gap);
        @(posedge clk_i);
        repeat (n) i_src.send(v, gap);
        i_src.stop();
    endtask

    task automatic pulse_end();
        @(posedge clk_i);
        burst_end_i <= 1'b1;
        @(posedge clk_i);
        burst_end_i <= 1'b0;
        #1;
        check({31'h0, tone_lock_o}, 32'h0, "lock after end");
    endtask

    // ==========================================================
    // Scenarios
    task automatic do_reset();
        repeat (3) @(posedge clk_i);
        check({31'h0, sample_ready_o}, 32'h0, "ready in reset");
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    // Lock only after four tone samples fill the chain; no word before it
    task automatic t_lock();
        pulse_end();
        feed(8'h60, 4, 0);
        #1;
        check({31'h0, tone_lock_o}, 32'h0, "early lock");
        feed(8'h60, 1, 0);
        #1;
        check({31'h0, tone_lock_o}, 32'h1, "lock");
        check(phases.size(), 0, "words before lock");
        feed(8'h60, 6, 1);
        repeat (4) @(posedge clk_i);
        check(phases.size(), 6, "locked words");
        foreach (phases[i]) check({20'h0, phases[i]}, 32'h0, "ideal tone");
    endtask

    // One sample 1h above the tone at unity gain: 61h*4000h field gives 10h
    task automatic t_scale();
        phases.delete();
        feed(8'h61, 1, 0);
        feed(8'h60, 8, 2);
        repeat (4) @(posedge clk_i);
        first_nz = 12'h000;
        foreach (phases[i]) if (first_nz === 12'h000) first_nz = phases[i];
        check({20'h0, first_nz}, 32'h10, "scaled step");
    endtask

    // Burst start clears the accumulator while no sample is offered
    task automatic t_start();
        @(posedge clk_i);
        burst_start_i <= 1'b1;
        @(posedge clk_i);
        burst_start_i <= 1'b0;
        phases.delete();
        feed(8'h60, 1, 0);
        repeat (4) @(posedge clk_i);
        check(phases.size(), 1, "word after start");
        if (phases.size() > 0) check({20'h0, phases[0]}, 32'h0, "cleared phase");
    endtask

    // Receiver stalls: two words fill the buffer, then the input refuses
    task automatic t_buffer();
        @(posedge clk_i);
        out_ready_i <= 1'b0;
        phases.delete();
        feed(8'h60, 2, 0);
        repeat (3) @(posedge clk_i);
        #1;
        check({31'h0, sample_ready_o}, 32'h0, "full refuses");
        check({31'h0, out_valid_o}, 32'h1, "held head");
        @(posedge clk_i);
        out_ready_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        check(phases.size(), 2, "drained words");
        check({31'h0, out_valid_o}, 32'h0, "empty");
        check({31'h0, sample_ready_o}, 32'h1, "room again");
    endtask

    // After burst end the relocking step pushes nothing
    task automatic t_end();
        pulse_end();
        phases.delete();
        feed(8'h60, 1, 0);
        repeat (4) @(posedge clk_i);
        check(phases.size(), 0, "word after end");
    endtask

    // Tracking from a fresh lock: one 61h sample puts 10h into the phase
    // at step 7; the lead term then moves only at step 8, so steps 9, 10
    // and 12 show 10h, 14h and 1ch (a fast loop would show 14h at step 9)
    task automatic t_track();
        @(posedge clk_i);
        data_mode_i <= 1'b1;
        phases.delete();
        feed(8'h61, 1, 0);
        feed(8'h60, 11, 0);
        repeat (4) @(posedge clk_i);
        check(phases.size(), 12, "tracking words");
        if (phases.size() == 12) begin
            check({20'h0, phases[8]}, 32'h10, "held lead term");
            check({20'h0, phases[9]}, 32'h14, "slow lead term");
            check({20'h0, phases[11]}, 32'h1c, "lead term steps");
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        t_lock();
        t_scale();
        t_start();
        t_buffer();
        t_end();
        t_track();
        close_out();
    end
endmodule
`default_nettype wire
